// ### design/pocd_regs.vh
/*
 * Register offsets, field positions and reset values of the paired
 * output clock divider.
 * Assumes a plain register port whose addresses are the printed
 * register offsets.
 */
`ifndef POCD_REGS_VH
`define POCD_REGS_VH

// ==========================================================
// Register offsets
`define POCD_A_CNT0  9'h190
`define POCD_A_CTL0  9'h191
`define POCD_A_RTE0  9'h192
`define POCD_A_CNT1  9'h193
`define POCD_A_CTL1  9'h194
`define POCD_A_RTE1  9'h195
`define POCD_A_STAT  9'h1a0
`define POCD_A_SRC   9'h1e1

// ==========================================================
// Field positions
`define POCD_LOW_HI   7
`define POCD_LOW_LO   4
`define POCD_HIGH_HI  3
`define POCD_HIGH_LO  0
`define POCD_BYP      7
`define POCD_NOSYNC   6
`define POCD_FORCE    5
`define POCD_START    4
`define POCD_PH_HI    3
`define POCD_PH_LO    0
`define POCD_DIRECT   1
`define POCD_DCC_OFF  0
`define POCD_SRC_HI   1
`define POCD_SRC_LO   0

// ==========================================================
// Clock source codes
`define POCD_SRC_EXT  2'h0
`define POCD_SRC_VIA  2'h1
`define POCD_SRC_OSC  2'h2

// ==========================================================
// Reset values
`define POCD_RST_CNT  8'h00
`define POCD_RST_CTL  8'h00
`define POCD_RST_RTE  8'h00
`define POCD_RST_SRC  8'h01

`endif

// ### design/pocd_regfile.v
/*
 * Configuration registers of both dividers and the clock source
 * select, with a registered read port.
 * Assumes one-cycle write and read strobes, never both at once.
 */
`include "pocd_regs.vh"

module pocd_regfile (
    input  wire       clock,
    input  wire       reset_n,
    input  wire [8:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] stat_in,
    output reg  [7:0] reg_rdata,
    output reg  [7:0] cnt0_reg,
    output reg  [7:0] ctl0_reg,
    output reg  [7:0] rte0_reg,
    output reg  [7:0] cnt1_reg,
    output reg  [7:0] ctl1_reg,
    output reg  [7:0] rte1_reg,
    output reg  [7:0] src_reg
);

    reg [7:0] rd_next;

    // ==========================================================
    // Write decode
    always @(posedge clock) begin
        if (!reset_n) begin
            cnt0_reg <= `POCD_RST_CNT;
            ctl0_reg <= `POCD_RST_CTL;
            rte0_reg <= `POCD_RST_RTE;
            cnt1_reg <= `POCD_RST_CNT;
            ctl1_reg <= `POCD_RST_CTL;
            rte1_reg <= `POCD_RST_RTE;
            src_reg  <= `POCD_RST_SRC;
        end else if (reg_wr) begin
            if (reg_addr == `POCD_A_CNT0) begin
                cnt0_reg <= reg_wdata;
            end else if (reg_addr == `POCD_A_CTL0) begin
                ctl0_reg <= reg_wdata;
            end else if (reg_addr == `POCD_A_RTE0) begin
                rte0_reg <= {6'h00, reg_wdata[1:0]};
            end else if (reg_addr == `POCD_A_CNT1) begin
                cnt1_reg <= reg_wdata;
            end else if (reg_addr == `POCD_A_CTL1) begin
                ctl1_reg <= reg_wdata;
            end else if (reg_addr == `POCD_A_RTE1) begin
                rte1_reg <= {6'h00, reg_wdata[1:0]};
            end else if (reg_addr == `POCD_A_SRC) begin
                src_reg <= {6'h00, reg_wdata[1:0]};
            end
        end
    end

    // ==========================================================
    // Read decode, unmapped offsets read zero
    always @* begin
        if (reg_addr == `POCD_A_CNT0) begin
            rd_next = cnt0_reg;
        end else if (reg_addr == `POCD_A_CTL0) begin
            rd_next = ctl0_reg;
        end else if (reg_addr == `POCD_A_RTE0) begin
            rd_next = rte0_reg;
        end else if (reg_addr == `POCD_A_CNT1) begin
            rd_next = cnt1_reg;
        end else if (reg_addr == `POCD_A_CTL1) begin
            rd_next = ctl1_reg;
        end else if (reg_addr == `POCD_A_RTE1) begin
            rd_next = rte1_reg;
        end else if (reg_addr == `POCD_A_SRC) begin
            rd_next = src_reg;
        end else if (reg_addr == `POCD_A_STAT) begin
            rd_next = stat_in;
        end else begin
            rd_next = 8'h00;
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_next : 8'h00;
        end
    end

endmodule // pocd_regfile

// ### design/pocd_route.v
/*
 * Output pair selector of one divider channel: divider output or a
 * direct path from the oscillator or the external clock input.
 * Assumes all inputs are levels synchronous to the clock.
 */
`include "pocd_regs.vh"

module pocd_route (
    input  wire       clock,
    input  wire       reset_n,
    input  wire       direct_bit,
    input  wire [1:0] src_sel,
    input  wire       div_out,
    input  wire       osc_level,
    input  wire       ext_level,
    output reg        pair_first,
    output reg        pair_second,
    output reg        direct_on
);

    reg sel_next;
    reg on_next;

    // ==========================================================
    // Path selection
    always @* begin
        sel_next = div_out;
        on_next  = 1'b0;
        if (direct_bit && src_sel == `POCD_SRC_OSC) begin
            sel_next = osc_level;
            on_next  = 1'b1;
        end else if (direct_bit && src_sel == `POCD_SRC_EXT) begin
            sel_next = ext_level;
            on_next  = 1'b1;
        end
    end

    // Both outputs of a pair carry the same clock
    always @(posedge clock) begin
        if (!reset_n) begin
            pair_first  <= 1'b0;
            pair_second <= 1'b0;
            direct_on   <= 1'b0;
        end else begin
            pair_first  <= sel_next;
            pair_second <= sel_next;
            direct_on   <= on_next;
        end
    end

endmodule // pocd_route

// ### design/pocd_top.v
/*
 * Two output-channel clock dividers, each driving one output pair,
 * with their configuration registers.
 * Assumes the clock is the divider input, and that chip_sync,
 * div_in_level, onchip_oscillator and ext_clock_in are synchronous.
 */
// The plain strobed port is this design's own decision.
// Behaviour
// - Low phase lasts low-count field cycles.
// - High phase lasts high-count field cycles.
// - Bypass powers divider down, passes input.
// - Sync-ignore bit makes divider disregard sync.
// - Force bit holds output static, needs sync-ignore.
// - Start-level bit picks initial output level.
// - Phase offset field sets coarse phase.
// - Direct bit clear: pair driven by divider.
// - Direct with source 10b: oscillator to pair.
// - Direct with source 00b: external clock to pair.
// - Source 01b: direct bit has no effect.
// - Correction disable bit turns correction off.
// - Two dividers at div0_cycle_counts and div1_cycle_counts.
`include "pocd_regs.vh"

module pocd_top (
    input  wire       clock,
    input  wire       reset_n,
    input  wire [8:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output wire [7:0] reg_rdata,
    input  wire       chip_sync,
    input  wire       div_in_level,
    input  wire       onchip_oscillator,
    input  wire       ext_clock_in,
    output wire       pair_a_first,
    output wire       pair_a_second,
    output wire       pair_b_first,
    output wire       pair_b_second,
    output wire [1:0] duty_correct_en
);

    // ==========================================================
    // Divider states
    localparam [1:0] ST_HOLD  = 2'b00;
    localparam [1:0] ST_PHASE = 2'b01;
    localparam [1:0] ST_RUN   = 2'b10;
    localparam [1:0] ST_OFF   = 2'b11;

    // ==========================================================
    // Last tick of a segment; a zero count still lasts one cycle
    function [3:0] seg_last;
        input [3:0] count;
        begin
            if (count == 4'h0) begin
                seg_last = 4'h0;
            end else begin
                seg_last = count - 4'h1;
            end
        end
    endfunction

    // Last tick of the segment that a level keeps
    function [3:0] seg_of;
        input       level;
        input [7:0] counts;
        begin
            if (level) begin
                seg_of = seg_last(counts[`POCD_HIGH_HI:`POCD_HIGH_LO]);
            end else begin
                seg_of = seg_last(counts[`POCD_LOW_HI:`POCD_LOW_LO]);
            end
        end
    endfunction

    // ==========================================================
    // Register file
    wire [7:0]  cnt0_w;
    wire [7:0]  ctl0_w;
    wire [7:0]  rte0_w;
    wire [7:0]  cnt1_w;
    wire [7:0]  ctl1_w;
    wire [7:0]  rte1_w;
    wire [7:0]  src_w;
    wire [7:0]  stat_w;
    wire [15:0] cnt_all;
    wire [15:0] ctl_all;
    wire [15:0] rte_all;
    wire [1:0]  div_out;
    wire [1:0]  running;
    wire [1:0]  level_now;
    wire [1:0]  direct_on;
    wire [1:0]  pair_first;
    wire [1:0]  pair_second;

    pocd_regfile u_regs (
        .clock     (clock),
        .reset_n   (reset_n),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .stat_in   (stat_w),
        .reg_rdata (reg_rdata),
        .cnt0_reg  (cnt0_w),
        .ctl0_reg  (ctl0_w),
        .rte0_reg  (rte0_w),
        .cnt1_reg  (cnt1_w),
        .ctl1_reg  (ctl1_w),
        .rte1_reg  (rte1_w),
        .src_reg   (src_w)
    );

    // Channel 0 sits in the low byte, channel 1 in the high byte
    assign cnt_all = {cnt1_w, cnt0_w};
    assign ctl_all = {ctl1_w, ctl0_w};
    assign rte_all = {rte1_w, rte0_w};

    // ==========================================================
    // Divider channels
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_div
            wire [7:0] cnt = cnt_all[i*8 +: 8];
            wire [7:0] ctl = ctl_all[i*8 +: 8];
            wire [7:0] rte = rte_all[i*8 +: 8];
            wire       byp    = ctl[`POCD_BYP];
            wire       nosync = ctl[`POCD_NOSYNC];
            wire       force_lvl = ctl[`POCD_FORCE];
            wire       start  = ctl[`POCD_START];
            wire [3:0] phase  = ctl[`POCD_PH_HI:`POCD_PH_LO];

            reg  [1:0] state_reg;
            reg  [1:0] state_next;
            reg  [3:0] tick_reg;
            reg  [3:0] tick_next;
            reg        level_reg;
            reg        level_next;
            reg        dcc_reg;
            reg        out_next;

            // Sync reaches the divider only when not ignored
            wire sync_obey = chip_sync & ~nosync;
            // Forcing applies while an ignored sync is present
            wire forcing   = chip_sync & nosync;

            // Next state of the counter and the output level
            always @* begin
                state_next = state_reg;
                tick_next  = tick_reg;
                level_next = level_reg;
                if (byp) begin
                    // Powered down: counter parked
                    state_next = ST_OFF;
                    tick_next  = 4'h0;
                    level_next = start;
                end else if (sync_obey) begin
                    // Held at the start level during sync
                    state_next = ST_HOLD;
                    tick_next  = 4'h0;
                    level_next = start;
                end else begin
                    case (state_reg)
                        ST_HOLD, ST_OFF: begin
                            level_next = start;
                            if (phase == 4'h0) begin
                                state_next = ST_RUN;
                                tick_next  = seg_of(start, cnt);
                            end else begin
                                state_next = ST_PHASE;
                                tick_next  = phase - 4'h1;
                            end
                        end
                        ST_PHASE: begin
                            if (tick_reg == 4'h0) begin
                                state_next = ST_RUN;
                                tick_next  = seg_of(level_reg, cnt);
                            end else begin
                                tick_next = tick_reg - 4'h1;
                            end
                        end
                        ST_RUN: begin
                            if (tick_reg == 4'h0) begin
                                level_next = ~level_reg;
                                // Low and high lengths from the
                                // counts register
                                tick_next  = seg_of(~level_reg,
                                                    cnt);
                            end else begin
                                tick_next = tick_reg - 4'h1;
                            end
                        end
                        default: begin
                            state_next = ST_HOLD;
                        end
                    endcase
                end
            end

            // Counter and level registers
            always @(posedge clock) begin
                if (!reset_n) begin
                    state_reg <= ST_HOLD;
                    tick_reg  <= 4'h0;
                    level_reg <= 1'b0;
                end else begin
                    state_reg <= state_next;
                    tick_reg  <= tick_next;
                    level_reg <= level_next;
                end
            end

            // Divider output: bypass, forced level or count
            always @* begin
                if (byp) begin
                    out_next = div_in_level;
                end else if (forcing) begin
                    out_next = force_lvl;
                end else begin
                    out_next = level_reg;
                end
            end

            // Correction runs only on an active divider
            always @(posedge clock) begin
                if (!reset_n) begin
                    dcc_reg <= 1'b0;
                end else begin
                    dcc_reg <= ~rte[`POCD_DCC_OFF] & ~byp;
                end
            end

            assign div_out[i]         = out_next;
            assign running[i]         = (state_reg == ST_RUN);
            assign level_now[i]       = level_reg;
            assign duty_correct_en[i] = dcc_reg;

            // Output pair selection
            pocd_route u_route (
                .clock       (clock),
                .reset_n     (reset_n),
                .direct_bit  (rte[`POCD_DIRECT]),
                .src_sel     (src_w[`POCD_SRC_HI:`POCD_SRC_LO]),
                .div_out     (div_out[i]),
                .osc_level   (onchip_oscillator),
                .ext_level   (ext_clock_in),
                .pair_first  (pair_first[i]),
                .pair_second (pair_second[i]),
                .direct_on   (direct_on[i])
            );
        end
    endgenerate

    // ==========================================================
    // Status word, four bits per channel
    assign stat_w = {direct_on[1], duty_correct_en[1],
                     running[1], level_now[1],
                     direct_on[0], duty_correct_en[0],
                     running[0], level_now[0]};

    // ==========================================================
    // Output pairs
    assign pair_a_first  = pair_first[0];
    assign pair_a_second = pair_second[0];
    assign pair_b_first  = pair_first[1];
    assign pair_b_second = pair_second[1];

endmodule // pocd_top

// ### testbench/pocd_monitor.sv
/* Port checker of the paired output clock divider.
   Assumes binding to pocd_top; shadows the channel 0 control and routing registers and the source register. */
module pocd_monitor (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       chip_sync,
    input wire logic       div_in_level,
    input wire logic       onchip_oscillator,
    input wire logic       ext_clock_in,
    input wire logic       pair_a_first,
    input wire logic       pair_a_second,
    input wire logic       pair_b_first,
    input wire logic       pair_b_second,
    input wire logic [1:0] duty_correct_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl0_reg;
    logic [1:0] rte0_reg;
    logic [1:0] src_reg;
    // ==========================================================
    // Shadow of the channel 0 control and routing registers and the source register
    always @(posedge clock) begin
        if (!reset_n) begin
            ctl0_reg <= 8'h00;
            rte0_reg <= 2'h0;
            src_reg  <= 2'h1;
        end else if (reg_wr) begin
            if (reg_addr == 9'h191) ctl0_reg <= reg_wdata;
            if (reg_addr == 9'h192) rte0_reg <= reg_wdata[1:0];
            if (reg_addr == 9'h1e1) src_reg <= reg_wdata[1:0];
        end
    end
    // ==========================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Condition held with settled registers and a steady level
    sequence steady(cond, lvl);
        (cond && $stable(lvl) && $stable(ctl0_reg) && $stable(rte0_reg)
         && $stable(src_reg))[*4];
    endsequence
    chk_pair_equal: assert property (pair_a_first == pair_a_second
        && pair_b_first == pair_b_second) else $error("pair split");
    chk_read_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 8'h00) else $error("read data not idle");
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 9'h100
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    chk_route_read: assert property (reg_rd && reg_addr == 9'h192
        |=> reg_rdata == {6'h00, rte0_reg}) else $error("routing read");
    chk_ctl_read: assert property (reg_rd && reg_addr == 9'h191
        |=> reg_rdata == ctl0_reg) else $error("control read");
    chk_bypass_pass: assert property (steady(ctl0_reg[7] &&
        (!rte0_reg[1] || src_reg[0]), div_in_level)
        |-> pair_a_first == div_in_level) else $error("bypass level");
    chk_force_level: assert property (steady(chip_sync &&
        ctl0_reg[6] && !ctl0_reg[7] && !rte0_reg[1], chip_sync)
        |-> pair_a_first == ctl0_reg[5]) else $error("force level");
    chk_direct_osc: assert property (steady(rte0_reg[1] &&
        src_reg == 2'h2, onchip_oscillator)
        |-> pair_a_first == onchip_oscillator) else $error("osc route");
    chk_direct_ext: assert property (steady(rte0_reg[1] &&
        src_reg == 2'h0, ext_clock_in)
        |-> pair_a_first == ext_clock_in) else $error("ext route");
    chk_dcc_flag: assert property (steady(1'b1, reset_n)
        |-> duty_correct_en[0] == (!rte0_reg[0] && !ctl0_reg[7]))
        else $error("correction flag");
endmodule // pocd_monitor

bind pocd_top pocd_monitor i_pocd_monitor (.clock(clock),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chip_sync(chip_sync), .div_in_level(div_in_level),
    .onchip_oscillator(onchip_oscillator), .ext_clock_in(ext_clock_in),
    .pair_a_first(pair_a_first), .pair_a_second(pair_a_second),
    .pair_b_first(pair_b_first), .pair_b_second(pair_b_second),
    .duty_correct_en(duty_correct_en));

// ### testbench/pocd_receiver.sv
/* Clock receiver on one output pair: measures run lengths.
   Assumes pair levels are synchronous to the clock. */
module pocd_receiver (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       pair_first,
    input  wire logic       pair_second,
    output logic      [7:0] high_len,
    output logic      [7:0] low_len,
    output logic            split
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_len;
    logic       last_level;
    // Store the length of each finished high or low run
    always @(posedge clock) begin
        if (!reset_n) begin
            {high_len, low_len, run_len} <= 24'h000001;
            {last_level, split} <= 2'h0;
        end else begin
            split <= split | (pair_first != pair_second);
            last_level <= pair_first;
            run_len <= run_len + 8'h01;
            if (pair_first != last_level) begin
                run_len <= 8'h01;
                if (last_level) high_len <= run_len;
                else low_len <= run_len;
            end
        end
    end
endmodule // pocd_receiver

// ### testbench/pocd_top_bench.sv
/* Self-checking bench of the paired output clock divider.
   Assumes the design files and the checker are compiled first. */
module pocd_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       chip_sync = 0, div_in_level = 0;
    logic       onchip_oscillator = 0, ext_clock_in = 0;
    wire  [7:0] reg_rdata, ha, la, hb, lb;
    wire  [1:0] duty_correct_en;
    wire        pa, pa2, pb, pb2, sa, sb;
    int         error_cnt = 0, comparisons = 0, cycles = 0;
    int         ta, tb;
    logic       exp;
    pocd_top i_pocd_top (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_sync(chip_sync),
        .div_in_level(div_in_level), .onchip_oscillator(onchip_oscillator),
        .ext_clock_in(ext_clock_in), .pair_a_first(pa),
        .pair_a_second(pa2), .pair_b_first(pb), .pair_b_second(pb2),
        .duty_correct_en(duty_correct_en));
    pocd_receiver i_pocd_receiver_a (.clock(clock), .reset_n(reset_n),
        .pair_first(pa), .pair_second(pa2), .high_len(ha), .low_len(la),
        .split(sa));
    pocd_receiver i_pocd_receiver_b (.clock(clock), .reset_n(reset_n),
        .pair_first(pb), .pair_second(pb2), .high_len(hb), .low_len(lb),
        .split(sb));
    // ==========================================================
    // Clock and hang guard
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] want);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, want);
    endtask
    task automatic hold(input logic s, input int n);
        @(posedge clock);
        chip_sync <= s;
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        for (int i = 0; i < 6; i++) rd(9'h190 + 9'(i), 8'h00);
        wr(9'h190, 8'ha5);
        wr(9'h194, 8'h3c);
        wr(9'h192, 8'hff);
        rd(9'h190, 8'ha5);
        rd(9'h194, 8'h3c);
        rd(9'h192, 8'h03);
        rd(9'h100, 8'h00);
        $display("regs done");
    endtask
    task automatic t_divide;
        wr(9'h192, 8'h00);
        wr(9'h191, 8'h00);
        wr(9'h194, 8'h00);
        wr(9'h190, 8'h32);
        wr(9'h193, 8'h14);
        hold(1'b0, 40);
        chk(ha, 8'h02);
        chk(la, 8'h03);
        chk(hb, 8'h04);
        chk(lb, 8'h01);
        $display("divide done");
    endtask
    task automatic t_phase;
        wr(9'h190, 8'h22);
        wr(9'h193, 8'h22);
        wr(9'h194, 8'h03);
        hold(1'b1, 4);
        chk({7'h0, pb}, 8'h00);
        hold(1'b0, 0);
        {ta, tb} = {-32'sd1, -32'sd1};
        for (int n = 0; n < 30; n++) begin
            @(posedge clock);
            #1;
            if (pa && ta < 0) ta = n;
            if (pb && tb < 0) tb = n;
        end
        chk(8'(tb - ta), 8'h03);
        wr(9'h194, 8'h10);
        hold(1'b1, 4);
        chk({7'h0, pa}, 8'h00);
        chk({7'h0, pb}, 8'h01);
        rd(9'h1a0, 8'h54);
        hold(1'b0, 0);
        $display("phase done");
    endtask
    task automatic t_force;
        wr(9'h191, 8'h60);
        wr(9'h194, 8'h00);
        hold(1'b1, 6);
        chk({7'h0, pa}, 8'h01);
        chk({7'h0, pb}, 8'h00);
        wr(9'h191, 8'h40);
        hold(1'b1, 6);
        chk({7'h0, pa}, 8'h00);
        hold(1'b0, 1);
        $display("force done");
    endtask
    task automatic t_bypass;
        wr(9'h191, 8'h80);
        wr(9'h195, 8'h01);
        div_in_level <= 1'b1;
        hold(1'b0, 4);
        chk({7'h0, pa}, 8'h01);
        chk({6'h0, duty_correct_en}, 8'h00);
        @(posedge clock);
        div_in_level <= 1'b0;
        wr(9'h195, 8'h00);
        hold(1'b0, 4);
        chk({7'h0, pa}, 8'h00);
        chk({6'h0, duty_correct_en}, 8'h02);
        $display("bypass done");
    endtask
    task automatic t_direct;
        wr(9'h192, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(9'h1e1, 8'(c));
            for (int p = 0; p < 3; p++) begin
                @(posedge clock);
                {onchip_oscillator, ext_clock_in, div_in_level} <=
                    3'b100 >> p;
                hold(1'b0, 4);
                exp = (c == 2) ? p == 0 : (c == 0) ? p == 1 : p == 2;
                chk({7'h0, pa}, {7'h0, exp});
            end
        end
        chk({6'h0, sa, sb}, 8'h00);
        $display("direct done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_regs();
        t_divide();
        t_phase();
        t_force();
        t_bypass();
        t_direct();
        end_of_test();
    end
endmodule // pocd_top_bench
